// [lvdc_top.sv]
// Added by the designer: register access over APB.
`timescale 1ns/10ps
// Contract
// - Control register at FFBE: enable b7, source b2, mode b1, flag b0, b6-3 zero.
// - Flag bit 0 is read-only; writes there are ignored.
// - Non-detector resets clear control; detector reset keeps enable, source, mode.
// - Enable 1 runs the comparator; 0 stops detection.
// - Source 0 selects supply rail comparison, 1 the external sense pin.
// - Interrupt mode raises the interrupt on falling below and on recovering.
// - Reset mode holds internal reset while below threshold, releases when above.
// - Flag reads 1 while below threshold, 0 when above or disabled.
// - Flag sets no sooner than 200 us after the voltage goes below.
// - Clearing enable while below in interrupt mode raises the interrupt.
// - Level code picks one of sixteen descending thresholds for the comparator.
// - Threshold register survives detector reset, cleared by every other reset.
// - External source uses a fixed threshold and ignores the level code.
// - Port direction register at FF2C resets to FF, bits 7-3 fixed at 1.
// - Direction bit 0 enables the output buffer, 1 disables it.
module lvdc_top
  import lvdc_pkg::*;
#(
  parameter int STAB_CYCLES  = lvdc_pkg::STABILIZE_CYCLES,
  parameter int DELAY_CYCLES = lvdc_pkg::FLAG_DELAY_CYCLES
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    detector_resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [15:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    cmp_supply_below,
  input  wire logic                    cmp_ext_below,
  output lvdc_pkg::lvdc_cmp_ctrl_s     cmp_ctrl,
  output logic                         detector_interrupt,
  output logic                         detector_irq_request_flag,
  input  wire logic                    irq_flag_clear,
  output logic                         internal_reset,
  output logic [2:0]                   port12_out_enable_n
);
  import lvdc_pkg::*;

  // ********************************************************************
  // Parameter checks
  // ********************************************************************
  initial begin
    if (STAB_CYCLES < 1 || DELAY_CYCLES < 1) begin
      $error("Timing counts must be at least one cycle");
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic        enable_ff;
  logic        source_ff;
  logic        mode_ff;
  logic [3:0]  level_ff;
  logic [2:0]  dir_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [1:0]  sup_sync_ff;
  logic [1:0]  ext_sync_ff;
  logic        flag_d_ff;
  logic        irq_ff;
  logic        irq_flag_ff;
  logic        rst_ff;
  lvdc_cmp_ctrl_s cmp_ctrl_ff;
  lvdc_state_e state_ff;
  lvdc_state_e nxt_state;
  logic [31:0] stab_cnt_ff;

  logic        wr_en;
  logic        rd_en;
  logic        sel_raw;
  logic        below_flag;
  logic        settled;
  logic        flag_edge;

  function automatic logic addr_known(input logic [15:0] a);
    return (a == ADDR_CONTROL) || (a == ADDR_THRESHOLD) ||
           (a == ADDR_PORT12_DIR) || (a == ADDR_STATUS);
  endfunction

  // ********************************************************************
  // APB slave: zero wait states, error on unmapped addresses
  // ********************************************************************
  // Read data is captured in the setup cycle so it stands through the access cycle
  assign wr_en = psel && penable && pwrite && addr_known(paddr) && pstrb[0];
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_known(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        ADDR_CONTROL:    prdata_ff <= {24'h0, enable_ff, 4'h0, source_ff, mode_ff,
                                       below_flag};
        ADDR_THRESHOLD:  prdata_ff <= {28'h0, level_ff};
        ADDR_PORT12_DIR: prdata_ff <= {24'h0, PORT12_FIXED[7:3], dir_ff};
        ADDR_STATUS:     prdata_ff <= {27'h0, state_ff, rst_ff, irq_flag_ff};
        default:         prdata_ff <= 32'h0;
      endcase
    end else begin
      prdata_ff <= 32'h0;
    end
  end

  // Control bits survive a detector reset; only the general reset clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= CONTROL_RESET[CTL_ENABLE_BIT];
      source_ff <= CONTROL_RESET[CTL_SOURCE_BIT];
      mode_ff   <= CONTROL_RESET[CTL_MODE_BIT];
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      enable_ff <= pwdata[CTL_ENABLE_BIT];
      source_ff <= pwdata[CTL_SOURCE_BIT];
      mode_ff   <= pwdata[CTL_MODE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= THRESHOLD_RESET[3:0];
    end else if (wr_en && paddr == ADDR_THRESHOLD) begin
      level_ff <= pwdata[3:0];
    end
  end

  // Direction is cleared by the general reset and by a detector reset alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_ff <= PORT12_RESET[2:0];
    end else if (!detector_resetn) begin
      dir_ff <= PORT12_RESET[2:0];
    end else if (wr_en && paddr == ADDR_PORT12_DIR) begin
      dir_ff <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port12_out_enable_n <= PORT12_RESET[2:0];
    end else begin
      port12_out_enable_n <= dir_ff;
    end
  end

  // ********************************************************************
  // Comparator control and synchronisers
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_ctrl_ff <= '0;
    end else begin
      cmp_ctrl_ff.enable     <= enable_ff;
      cmp_ctrl_ff.source_ext <= source_ff;
      cmp_ctrl_ff.reset_mode <= mode_ff;
      // Fixed external reference makes the code irrelevant there
      cmp_ctrl_ff.level_code <= source_ff ? EXT_LEVEL_CODE : level_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_sync_ff <= 2'b00;
      ext_sync_ff <= 2'b00;
    end else begin
      sup_sync_ff <= {sup_sync_ff[0], cmp_supply_below};
      ext_sync_ff <= {ext_sync_ff[0], cmp_ext_below};
    end
  end

  assign sel_raw = source_ff ? ext_sync_ff[1] : sup_sync_ff[1];

  // ********************************************************************
  // Enable sequencing: results ignored until the comparator settles
  // ********************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LVDC_OFF:    nxt_state = enable_ff ? LVDC_SETTLE : LVDC_OFF;
      LVDC_SETTLE: begin
        if (!enable_ff) begin
          nxt_state = LVDC_OFF;
        end else if (stab_cnt_ff >= 32'(STAB_CYCLES - 1)) begin
          nxt_state = LVDC_ACTIVE;
        end
      end
      LVDC_ACTIVE: nxt_state = enable_ff ? LVDC_ACTIVE : LVDC_OFF;
      default:     nxt_state = LVDC_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= LVDC_OFF;
      stab_cnt_ff <= 32'h0;
    end else begin
      state_ff    <= nxt_state;
      stab_cnt_ff <= (state_ff == LVDC_SETTLE) ? stab_cnt_ff + 32'h1 : 32'h0;
    end
  end

  assign settled = (state_ff == LVDC_ACTIVE);

  lvdc_filter #(
    .DELAY_CYCLES (DELAY_CYCLES)
  ) lvdc_filter_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .run       (settled && enable_ff),
    .below_in  (sel_raw),
    .below_out (below_flag)
  );

  // ********************************************************************
  // Interrupt and reset generation
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_d_ff <= 1'b0;
    end else begin
      flag_d_ff <= below_flag;
    end
  end

  // Any flag change in interrupt mode is one event: a pulse and a sticky request
  assign flag_edge = !mode_ff && (below_flag != flag_d_ff);

  // Dropping enable while below reads as a recovery edge, so it interrupts too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_edge;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_ff <= 1'b0;
    end else if (flag_edge) begin
      irq_flag_ff <= 1'b1;
    end else if (irq_flag_clear) begin
      irq_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_ff <= 1'b0;
    end else begin
      rst_ff <= mode_ff && enable_ff && below_flag;
    end
  end

  assign prdata                    = prdata_ff;
  assign pready                    = pready_ff;
  assign pslverr                   = pslverr_ff;
  assign cmp_ctrl                  = cmp_ctrl_ff;
  assign detector_interrupt        = irq_ff;
  assign detector_irq_request_flag = irq_flag_ff;
  assign internal_reset            = rst_ff;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flag_low_off: assert property (!enable_ff |-> ##1 !below_flag)
    else $error("Flag set while detector disabled");
  a_reset_follow: assert property (mode_ff && enable_ff && below_flag |=> rst_ff)
    else $error("Internal reset not raised while below");
  a_reset_release: assert property (!below_flag |=> !rst_ff)
    else $error("Internal reset held above threshold");
  a_irq_edge: assert property (!mode_ff && $rose(below_flag) |=> irq_ff)
    else $error("No interrupt on falling below");
  a_irq_recover: assert property (!mode_ff && $fell(below_flag) |=> irq_ff)
    else $error("No interrupt on recovery");
  a_irq_pulse: assert property (irq_ff |=> !irq_ff || $changed(flag_d_ff))
    else $error("Interrupt wider than one cycle");
  a_irq_flag_set: assert property (irq_ff |-> irq_flag_ff)
    else $error("Request flag missed an interrupt");
  a_no_irq_reset: assert property (mode_ff && $past(mode_ff) |-> !irq_ff)
    else $error("Interrupt in reset mode");
  a_ext_code: assert property (source_ff |=> cmp_ctrl.level_code == EXT_LEVEL_CODE)
    else $error("Level code not fixed for external source");
  a_dir_fixed: assert property (rd_en && paddr == ADDR_PORT12_DIR |=>
                                prdata[7:3] == 5'h1f)
    else $error("Fixed direction bits not one");
  a_flag_delay: assert property ($rose(below_flag) |-> $past(sel_raw, 2))
    else $error("Flag set without a sustained low");
  // A detector reset must leave the control and threshold state alone
  a_ctrl_kept: assert property (!detector_resetn && !wr_en |=>
                                $stable({enable_ff, source_ff, mode_ff, level_ff}))
    else $error("Control state changed by detector reset");
  a_dir_cleared: assert property (!detector_resetn |=> dir_ff == PORT12_RESET[2:0])
    else $error("Direction not returned to input by detector reset");
  // The flag stays low until the comparator has had its settle time
  a_settle_quiet: assert property (!settled |=> !below_flag)
    else $error("Flag set before the comparator settled");
  a_out_enable: assert property (port12_out_enable_n == $past(dir_ff))
    else $error("Output enables do not follow direction bits");
  a_rst_mode_only: assert property (rst_ff |-> $past(mode_ff) && $past(enable_ff))
    else $error("Internal reset outside reset mode");
  a_cmp_enable: assert property (cmp_ctrl.enable == $past(enable_ff))
    else $error("Comparator enable does not follow control");
  a_level_code: assert property (!source_ff |=> cmp_ctrl.level_code == $past(level_ff))
    else $error("Level code not passed to comparator");

  // ********************************************************************
  // Cover points
  // ********************************************************************
  c_irq:    cover property (irq_ff);
  c_reset:  cover property (rst_ff);
  c_settle: cover property (state_ff == LVDC_ACTIVE);
  c_err:    cover property (pslverr);
  c_off:    cover property (!mode_ff && $fell(enable_ff) && below_flag);

endmodule

// [lvdc_pkg.sv]
package lvdc_pkg;

  // ********************************************************************
  // Register map (byte addresses on APB)
  // ********************************************************************
  localparam logic [15:0] ADDR_PORT12_DIR  = 16'hff2c;
  localparam logic [15:0] ADDR_CONTROL     = 16'hffbe;
  localparam logic [15:0] ADDR_THRESHOLD   = 16'hffbf;
  // Status view of the block's internal state, read only
  localparam logic [15:0] ADDR_STATUS      = 16'hffc0;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int CTL_ENABLE_BIT  = 7;
  localparam int CTL_SOURCE_BIT  = 2;
  localparam int CTL_MODE_BIT    = 1;
  localparam int CTL_FLAG_BIT    = 0;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET  = 8'h00;
  localparam logic [7:0] PORT12_RESET     = 8'hff;
  localparam logic [7:0] PORT12_FIXED     = 8'hf8;
  localparam logic [3:0] EXT_LEVEL_CODE   = 4'hf;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_MHZ            = 250;
  localparam int STABILIZE_US       = 10;
  localparam int FLAG_DELAY_US      = 200;
  localparam int STABILIZE_CYCLES   = STABILIZE_US * CLK_MHZ;
  localparam int FLAG_DELAY_CYCLES  = FLAG_DELAY_US * CLK_MHZ;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic       enable;
    logic       source_ext;
    logic       reset_mode;
    logic [3:0] level_code;
  } lvdc_cmp_ctrl_s;

  typedef enum logic [2:0] {
    LVDC_OFF    = 3'b001,
    LVDC_SETTLE = 3'b010,
    LVDC_ACTIVE = 3'b100
  } lvdc_state_e;

endpackage

// [lvdc_filter.sv]
`timescale 1ns/10ps
module lvdc_filter #(
  parameter int DELAY_CYCLES = 50000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic below_in,
  output logic      below_out
);

  logic [31:0] cnt_ff;
  logic        below_ff;

  initial begin
    if (DELAY_CYCLES < 1) begin
      $error("DELAY_CYCLES must be at least one");
    end
  end

  // Setting waits a full delay of continuous low; clearing is immediate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 32'h0;
      below_ff <= 1'b0;
    end else if (!run || !below_in) begin
      cnt_ff   <= 32'h0;
      below_ff <= 1'b0;
    end else if (cnt_ff >= 32'(DELAY_CYCLES - 1)) begin
      below_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end

  assign below_out = below_ff;

endmodule

// [lvdc_cmp_model.sv]
`timescale 1ns/10ps
module lvdc_cmp_model
  import lvdc_pkg::*;
(
  input  wire lvdc_pkg::lvdc_cmp_ctrl_s cmp_ctrl,
  input  wire logic [15:0]              supply_mv,
  input  wire logic [15:0]              ext_mv,
  output logic                          cmp_supply_below,
  output logic                          cmp_ext_below
);
  // ********************************************************************
  // Analog comparator, millivolt levels
  // ********************************************************************
  localparam int LEVEL_MV [16] = '{4240, 4090, 3930, 3780, 3620, 3470, 3320, 3160,
                                   3010, 2850, 2700, 2550, 2390, 2240, 2080, 1930};
  localparam int EXT_MV = 1210;
  // A stopped comparator holds both outputs low
  assign cmp_supply_below = cmp_ctrl.enable && (int'(supply_mv) < LEVEL_MV[cmp_ctrl.level_code]);
  assign cmp_ext_below    = cmp_ctrl.enable && (int'(ext_mv) < EXT_MV);
endmodule

// [lvdc_top_tb.sv]
`timescale 1ns/10ps
module lvdc_top_tb;
  import lvdc_pkg::*;
  localparam int STAB = 4;
  localparam int DLY  = 8;
  logic pclk = 0, presetn = 0, detector_resetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0, supply_mv = 16'd5000, ext_mv = 16'd1500;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, cmp_supply_below, cmp_ext_below, irq_flag_clear = 0;
  logic detector_interrupt, detector_irq_request_flag, internal_reset;
  logic [2:0] port12_out_enable_n;
  lvdc_cmp_ctrl_s cmp_ctrl;
  int n_errors = 0, check_count = 0;

  always #2 pclk = ~pclk;

  lvdc_top #(.STAB_CYCLES(STAB), .DELAY_CYCLES(DLY)) lvdc_top_i (.pclk(pclk), .presetn(presetn),
    .detector_resetn(detector_resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_supply_below(cmp_supply_below), .cmp_ext_below(cmp_ext_below),
    .cmp_ctrl(cmp_ctrl), .detector_interrupt(detector_interrupt),
    .detector_irq_request_flag(detector_irq_request_flag), .irq_flag_clear(irq_flag_clear),
    .internal_reset(internal_reset), .port12_out_enable_n(port12_out_enable_n));

  lvdc_cmp_model lvdc_cmp_model_i (.cmp_ctrl(cmp_ctrl), .supply_mv(supply_mv), .ext_mv(ext_mv),
    .cmp_supply_below(cmp_supply_below), .cmp_ext_below(cmp_ext_below));

  // ********************************************************************
  // Bus and check helpers
  // ********************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_d, output logic err);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_d = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1, a, d, x, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string m);
    logic [31:0] x;
    logic e;
    apb(0, a, 0, x, e);
    chk(x, exp, m);
  endtask

  // Polls at the falling edge so a one-cycle pulse cannot slip past
  task automatic wait_for(input int sel, input logic lvl);
    int k;
    k = 0;
    while (k < 100 && (sel == 0 ? detector_interrupt : internal_reset) !== lvl) begin
      @(negedge pclk);
      k++;
    end
  endtask

  task automatic irq_clear();
    @(posedge pclk);
    irq_flag_clear <= 1;
    @(posedge pclk);
    irq_flag_clear <= 0;
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_regs();
    logic [31:0] x;
    logic e;
    rd(ADDR_CONTROL, 32'h00, "control reset");
    rd(ADDR_PORT12_DIR, 32'hff, "direction reset");
    chk(port12_out_enable_n, 3'b111, "buffers off");
    wr(ADDR_CONTROL, 32'hff);
    rd(ADDR_CONTROL, 32'h86, "flag and spare bits");
    wr(ADDR_CONTROL, 32'h00);
    pstrb <= 4'h0;
    wr(ADDR_CONTROL, 32'h80);
    pstrb <= 4'hf;
    rd(ADDR_CONTROL, 32'h00, "strobe off");
    wr(ADDR_THRESHOLD, 32'hff);
    rd(ADDR_THRESHOLD, 32'h0f, "level code");
    wr(ADDR_PORT12_DIR, 32'h01);
    rd(ADDR_PORT12_DIR, 32'hf9, "direction bits");
    chk(port12_out_enable_n, 3'b001, "buffers on");
    apb(0, 16'h0010, 0, x, e);
    chk(e, 1, "unmapped error");
    chk(x, 0, "unmapped data");
  endtask

  task automatic t_resets();
    wr(ADDR_CONTROL, 32'h06);
    @(posedge pclk);
    detector_resetn <= 0;
    @(posedge pclk);
    detector_resetn <= 1;
    rd(ADDR_CONTROL, 32'h06, "control kept");
    rd(ADDR_THRESHOLD, 32'h0f, "threshold kept");
    rd(ADDR_PORT12_DIR, 32'hff, "direction cleared");
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    rd(ADDR_CONTROL, 32'h00, "control cleared");
    rd(ADDR_THRESHOLD, 32'h00, "threshold cleared");
  endtask

  task automatic t_irq_mode();
    wr(ADDR_THRESHOLD, 32'h00);
    wr(ADDR_CONTROL, 32'h80);
    repeat (STAB + 4) @(posedge pclk);
    supply_mv <= 16'd4000;
    rd(ADDR_CONTROL, 32'h80, "flag too early");
    wait_for(0, 1);
    chk(detector_interrupt, 1, "falling irq");
    @(negedge pclk);
    chk(detector_interrupt, 0, "single pulse");
    rd(ADDR_CONTROL, 32'h81, "flag below");
    chk(detector_irq_request_flag, 1, "request set");
    irq_clear();
    supply_mv <= 16'd5000;
    @(negedge pclk);
    chk(detector_irq_request_flag, 0, "request cleared");
    wait_for(0, 1);
    chk(detector_interrupt, 1, "rising irq");
    rd(ADDR_CONTROL, 32'h80, "flag above");
    supply_mv <= 16'd4000;
    wait_for(0, 1);
    chk(detector_interrupt, 1, "falling irq again");
    irq_clear();
    wr(ADDR_CONTROL, 32'h00);
    repeat (6) @(negedge pclk);
    chk(detector_irq_request_flag, 1, "irq on disable");
    rd(ADDR_CONTROL, 32'h00, "flag disabled");
    rd(ADDR_STATUS, 32'h05, "status off with request");
    supply_mv <= 16'd1000;
  endtask

  task automatic t_reset_mode();
    wr(ADDR_PORT12_DIR, 32'h01);
    wr(ADDR_CONTROL, 32'h86);
    repeat (STAB + DLY + 6) @(posedge pclk);
    chk(cmp_ctrl.level_code, 4'hf, "fixed level");
    chk(internal_reset, 0, "supply ignored");
    ext_mv <= 16'd1000;
    wait_for(1, 1);
    chk(internal_reset, 1, "reset asserted");
    rd(ADDR_CONTROL, 32'h87, "flag external");
    ext_mv <= 16'd1500;
    wait_for(1, 0);
    chk(internal_reset, 0, "reset released");
    wr(ADDR_CONTROL, 32'h00);
  endtask

  // ********************************************************************
  // Sequence and verdict
  // ********************************************************************
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_resets();
    t_irq_mode();
    t_reset_mode();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
endmodule
